// ===== core/dpg_pkg.sv
// constants, field layouts and state codes of the dual pot/gain serial slave
// assumes a single 125 MHz clock domain
package dpg_pkg;

    localparam logic [7:0] REG_POT0       = 8'hf8;
    localparam logic [7:0] REG_POT1       = 8'hf9;
    localparam logic [7:0] REG_POT_BOTH   = 8'hfa;
    localparam logic [7:0] REG_GAIN       = 8'hfb;
    localparam logic [7:0] READ_NONE      = 8'h00;

    localparam logic [5:0] POT_RESET      = 6'h1f;
    localparam logic [2:0] GAIN_RESET     = 3'h1;
    localparam int         POT_W          = 6;
    localparam int         GAIN_W         = 3;
    localparam int         GAIN0_LSB      = 0;
    localparam int         GAIN1_LSB      = 4;

    localparam logic [3:0] DEV_ADDR_HI    = 4'ha;
    localparam logic [2:0] BIT_LAST       = 3'h7;

    localparam logic [1:0] BYTE_ADDR      = 2'h0;
    localparam logic [1:0] BYTE_REG       = 2'h1;
    localparam logic [1:0] BYTE_DATA      = 2'h2;

    localparam int NV_STORE_TIME_MS = 20;
    localparam int CLK_FREQ_HZ      = 125_000_000;
    localparam int STORE_CYCLES     = NV_STORE_TIME_MS * (CLK_FREQ_HZ / 1000);

    typedef enum logic [8:0] {
        ST_IDLE    = 9'h001,
        ST_RX      = 9'h002,
        ST_RX_END  = 9'h004,
        ST_ACK     = 9'h008,
        ST_TX      = 9'h010,
        ST_TX_END  = 9'h020,
        ST_TX_ACK  = 9'h040,
        ST_TX_MORE = 9'h080,
        ST_IGNORE  = 9'h100
    } dpg_state_t;

endpackage : dpg_pkg

// ===== core/dpg_bus_if.sv
// bus events passed from the line watcher to the slave core
// assumes both ends run on the same clock
`timescale 1ns/100ps
interface dpg_bus_if;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic sda_level;

    modport phy  (output scl_rise, scl_fall, start_det, stop_det, sda_level);
    modport core (input  scl_rise, scl_fall, start_det, stop_det, sda_level);
endinterface : dpg_bus_if

// ===== core/dpg_bus_phy.sv
// edge and start/stop detector for the serial clock and data lines
// assumes scl and sda are already synchronous to clock
`timescale 1ns/100ps
module dpg_bus_phy (
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic scl,
    input  wire logic sda,
    dpg_bus_if.phy    bus
);
    logic scl_q;
    logic sda_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end

    assign bus.scl_rise  = scl & ~scl_q;
    assign bus.scl_fall  = ~scl & scl_q;
    assign bus.start_det = scl & scl_q & sda_q & ~sda;
    assign bus.stop_det  = scl & scl_q & ~sda_q & sda;
    assign bus.sda_level = sda;
endmodule : dpg_bus_phy

// ===== core/dpg_i2c_slave.sv
// serial slave front end: addressing, pointer, live settings and store timing
// assumes open-drain sda resolved outside; sda_oe high pulls the line low
`timescale 1ns/100ps

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - reads shift eight bits msb first; master nack ends read, line released
// - first byte after start is seven address bits plus direction bit
// - three low address bits come from the strap pins, ground zero
// - direction zero is a write, one is a read
// - wrong address: stay silent until the next start
// - second byte of a write selects the target register
// - live setting changes once the data byte is acknowledged
// - store only after stop; repeated start updates without storing
// - further data bytes rewrite the same register, pointer holds
// - own address not acknowledged while a store runs
// - reads use the current pointer, not an address in the read
// - pointer loads from register byte even with no data following
// - two 6-bit wipers default 1fh, top bits dropped, fah writes both
// - gain register default 11h, one nibble per amplifier, top bit reserved
// - settings change only with lock pin low; reads allowed at either lock level
// - sample on rising scl, change own output after falling scl
module dpg_i2c_slave #(
    parameter int STORE_CYCLES = dpg_pkg::STORE_CYCLES
) (
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire logic                      scl,
    input  wire logic                      sda,
    output logic                           sda_out,
    output logic                           sda_oe,
    input  wire logic                      addr_strap_bit0,
    input  wire logic                      addr_strap_bit1,
    input  wire logic                      addr_strap_bit2,
    input  wire logic                      write_lock,
    output logic [dpg_pkg::POT_W-1:0]      pot0_code,
    output logic [dpg_pkg::POT_W-1:0]      pot1_code,
    output logic [dpg_pkg::GAIN_W-1:0]     gain_stage_zero,
    output logic [dpg_pkg::GAIN_W-1:0]     gain_stage_one,
    output logic                           nv_busy,
    output logic                           nv_store_start
);
    localparam int CNT_W = $clog2(STORE_CYCLES + 1);

    generate
        if (STORE_CYCLES < 1) begin : g_bad_store
            $error("STORE_CYCLES must be at least one");
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // line events

    dpg_bus_if bus ();

    dpg_bus_phy u_phy (
        .clock (clock),
        .rst   (rst),
        .scl   (scl),
        .sda   (sda),
        .bus   (bus)
    );

    //////////////////////////////////////////////////////////////////////////
    // state

    dpg_pkg::dpg_state_t st;
    logic [7:0]          rx_shift;
    logic [7:0]          tx_shift;
    logic [2:0]          bit_cnt;
    logic [1:0]          byte_idx;
    logic                rw;
    logic [7:0]          pointer;
    logic                dirty;
    logic [2:0]          strap;
    logic [CNT_W-1:0]    busy_cnt;

    wire       bus_evt     = bus.start_det | bus.stop_det;
    wire       addr_match  = rx_shift[7:1] == {dpg_pkg::DEV_ADDR_HI, strap};
    wire       addr_ok     = addr_match & ~nv_busy;
    wire       ack_ok      = (byte_idx != dpg_pkg::BYTE_ADDR) | addr_ok;
    wire       ack_end     = (st == dpg_pkg::ST_ACK) & bus.scl_fall & ~bus_evt;
    wire       data_write  = ack_end & ~rw & (byte_idx == dpg_pkg::BYTE_DATA);
    wire       wr_fire     = data_write & ~write_lock;
    wire       wr_pot0     = wr_fire & ((pointer == dpg_pkg::REG_POT0) | (pointer == dpg_pkg::REG_POT_BOTH));
    wire       wr_pot1     = wr_fire & ((pointer == dpg_pkg::REG_POT1) | (pointer == dpg_pkg::REG_POT_BOTH));
    wire       wr_gain     = wr_fire & (pointer == dpg_pkg::REG_GAIN);
    wire       wr_hit      = wr_pot0 | wr_pot1 | wr_gain;
    wire       go_tx       = ack_end & rw & (byte_idx == dpg_pkg::BYTE_ADDR);
    wire       tx_reload   = (st == dpg_pkg::ST_TX_MORE) & bus.scl_fall & ~bus_evt;
    wire       commit      = bus.stop_det & dirty;

    // read mux from the pointer; the write-only and unmapped addresses read zero
    wire [7:0] gain_rd     = {1'b0, gain_stage_one, 1'b0, gain_stage_zero};
    wire [7:0] read_data   = (pointer == dpg_pkg::REG_POT0) ? {2'b00, pot0_code} :
                             (pointer == dpg_pkg::REG_POT1) ? {2'b00, pot1_code} :
                             (pointer == dpg_pkg::REG_GAIN) ? gain_rd :
                                                              dpg_pkg::READ_NONE;

    //////////////////////////////////////////////////////////////////////////
    // protocol engine

    always_ff @(posedge clock) begin
        if (rst) begin
            strap <= 3'h0;
        end else begin
            strap <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            st       <= dpg_pkg::ST_IDLE;
            rx_shift <= 8'h00;
            tx_shift <= 8'h00;
            bit_cnt  <= 3'h0;
            byte_idx <= dpg_pkg::BYTE_ADDR;
            rw       <= 1'b0;
            pointer  <= 8'h00;
            sda_oe   <= 1'b0;
        end else if (bus.start_det) begin
            st       <= dpg_pkg::ST_RX;
            bit_cnt  <= 3'h0;
            byte_idx <= dpg_pkg::BYTE_ADDR;
            sda_oe   <= 1'b0;
        end else if (bus.stop_det) begin
            st     <= dpg_pkg::ST_IDLE;
            sda_oe <= 1'b0;
        end else begin
            case (st)
                dpg_pkg::ST_RX: begin
                    if (bus.scl_rise) begin
                        rx_shift <= {rx_shift[6:0], bus.sda_level};
                        bit_cnt  <= bit_cnt + 3'h1;
                        if (bit_cnt == dpg_pkg::BIT_LAST) begin
                            st <= dpg_pkg::ST_RX_END;
                        end
                    end
                end
                dpg_pkg::ST_RX_END: begin
                    if (bus.scl_fall) begin
                        if (byte_idx == dpg_pkg::BYTE_ADDR) begin
                            rw <= rx_shift[0];
                        end
                        sda_oe <= ack_ok;
                        st     <= ack_ok ? dpg_pkg::ST_ACK : dpg_pkg::ST_IGNORE;
                    end
                end
                dpg_pkg::ST_ACK: begin
                    if (bus.scl_fall) begin
                        bit_cnt <= 3'h0;
                        if (go_tx) begin
                            tx_shift <= read_data;
                            sda_oe   <= ~read_data[7];
                            st       <= dpg_pkg::ST_TX;
                        end else begin
                            sda_oe <= 1'b0;
                            st     <= dpg_pkg::ST_RX;
                            if (byte_idx == dpg_pkg::BYTE_REG) begin
                                pointer <= rx_shift;
                            end
                            if (byte_idx != dpg_pkg::BYTE_DATA) begin
                                byte_idx <= byte_idx + 2'h1;
                            end
                        end
                    end
                end
                dpg_pkg::ST_TX: begin
                    if (bus.scl_rise) begin
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == dpg_pkg::BIT_LAST) begin
                            st <= dpg_pkg::ST_TX_END;
                        end
                    end else if (bus.scl_fall) begin
                        tx_shift <= {tx_shift[6:0], 1'b0};
                        sda_oe   <= ~tx_shift[6];
                    end
                end
                dpg_pkg::ST_TX_END: begin
                    if (bus.scl_fall) begin
                        sda_oe <= 1'b0;
                        st     <= dpg_pkg::ST_TX_ACK;
                    end
                end
                dpg_pkg::ST_TX_ACK: begin
                    if (bus.scl_rise) begin
                        // a nack hands the line back to the master for good
                        st <= bus.sda_level ? dpg_pkg::ST_IGNORE : dpg_pkg::ST_TX_MORE;
                    end
                end
                dpg_pkg::ST_TX_MORE: begin
                    if (tx_reload) begin
                        bit_cnt  <= 3'h0;
                        tx_shift <= read_data;
                        sda_oe   <= ~read_data[7];
                        st       <= dpg_pkg::ST_TX;
                    end
                end
                dpg_pkg::ST_IDLE, dpg_pkg::ST_IGNORE: begin
                    sda_oe <= 1'b0;
                end
                default: begin
                    st     <= dpg_pkg::ST_IDLE;
                    sda_oe <= 1'b0;
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // live settings, updated at the end of the data acknowledge

    always_ff @(posedge clock) begin
        if (rst) begin
            pot0_code       <= dpg_pkg::POT_RESET;
            pot1_code       <= dpg_pkg::POT_RESET;
            gain_stage_zero <= dpg_pkg::GAIN_RESET;
            gain_stage_one  <= dpg_pkg::GAIN_RESET;
        end else begin
            if (wr_pot0) begin
                pot0_code <= rx_shift[dpg_pkg::POT_W-1:0];
            end
            if (wr_pot1) begin
                pot1_code <= rx_shift[dpg_pkg::POT_W-1:0];
            end
            if (wr_gain) begin
                gain_stage_zero <= rx_shift[dpg_pkg::GAIN0_LSB +: dpg_pkg::GAIN_W];
                gain_stage_one  <= rx_shift[dpg_pkg::GAIN1_LSB +: dpg_pkg::GAIN_W];
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // store tracking: a repeated start drops the pending store

    always_ff @(posedge clock) begin
        if (rst) begin
            dirty <= 1'b0;
        end else if (bus_evt) begin
            dirty <= 1'b0;
        end else if (wr_hit) begin
            dirty <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            busy_cnt       <= '0;
            nv_busy        <= 1'b0;
            nv_store_start <= 1'b0;
        end else begin
            nv_store_start <= commit;
            if (commit) begin
                busy_cnt <= CNT_W'(STORE_CYCLES);
                nv_busy  <= 1'b1;
            end else if (busy_cnt != '0) begin
                busy_cnt <= busy_cnt - 1'b1;
                nv_busy  <= busy_cnt != CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end
endmodule : dpg_i2c_slave

// ===== verification/dpg_slave_monitor.sv
// concurrent checks on the top ports of the pot/gain serial slave
// assumes one clock domain and the synchronous active high reset
`timescale 1ns/100ps
module dpg_slave_monitor #(
    parameter int STORE_CYCLES = 20
) (
    input wire logic                       clock,
    input wire logic                       rst,
    input wire logic                       scl,
    input wire logic                       sda,
    input wire logic                       sda_out,
    input wire logic                       sda_oe,
    input wire logic                       write_lock,
    input wire logic                       nv_busy,
    input wire logic                       nv_store_start,
    input wire logic [dpg_pkg::POT_W-1:0]  pot0_code,
    input wire logic [dpg_pkg::POT_W-1:0]  pot1_code,
    input wire logic [dpg_pkg::GAIN_W-1:0] gain_stage_zero,
    input wire logic [dpg_pkg::GAIN_W-1:0] gain_stage_one
);
    int busy_len;
    // length of the current busy interval, checked when it ends
    always_ff @(posedge clock) begin
        if (rst || !nv_busy) begin
            busy_len <= 0;
        end else begin
            busy_len <= busy_len + 1;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    property p_open_drain; sda_out == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("sda_out driven high");
    property p_pulse; nv_store_start |-> nv_busy ##1 !nv_store_start; endproperty
    a_pulse: assert property (p_pulse) else $error("store pulse malformed");
    property p_after_stop; nv_store_start |-> sda && scl; endproperty
    a_after_stop: assert property (p_after_stop) else $error("store not after stop");
    property p_busy_len; $fell(nv_busy) |-> busy_len == STORE_CYCLES; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
    property p_silent; nv_busy |-> !sda_oe; endproperty
    a_silent: assert property (p_silent) else $error("line pulled while busy");
    property p_lock;
        write_lock && $past(write_lock) |-> $stable({pot0_code, pot1_code, gain_stage_zero, gain_stage_one});
    endproperty
    a_lock: assert property (p_lock) else $error("setting changed while locked");
    property p_live; $changed({pot0_code, pot1_code, gain_stage_zero, gain_stage_one}) |-> !scl; endproperty
    a_live: assert property (p_live) else $error("setting changed outside ack");
    property p_oe_low; $changed(sda_oe) |-> !scl; endproperty
    a_oe_low: assert property (p_oe_low) else $error("sda_oe moved with scl high");
    c_store: cover property (nv_store_start);
    c_ack: cover property (sda_oe && scl);
    c_done: cover property ($fell(nv_busy));
endmodule : dpg_slave_monitor

bind dpg_i2c_slave dpg_slave_monitor #(.STORE_CYCLES(STORE_CYCLES)) i_dpg_slave_monitor (.clock, .rst, .scl,
    .sda, .sda_out, .sda_oe, .write_lock, .nv_busy, .nv_store_start, .pot0_code, .pot1_code,
    .gain_stage_zero, .gain_stage_one);

// ===== verification/dpg_master_model.sv
// bus master model: start, stop and byte transfers on scl and an open-drain pull
// assumes a pull-up on sda; scl phases of four clocks keep the slave's two-clock minimum
`timescale 1ns/100ps
module dpg_master_model (
    input  wire logic clock,
    input  wire logic sda,
    output logic      scl,
    output logic      master_pull
);
    initial begin
        scl = 1'b1;
        master_pull = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : wait_clk
    // the second sda move happens while scl is high, which is what makes start or stop
    task automatic line_cond(input logic first, input logic second);
        master_pull = first;
        wait_clk(2);
        scl = 1'b1;
        wait_clk(4);
        master_pull = second;
        wait_clk(4);
    endtask : line_cond
    task automatic start_cond();
        line_cond(1'b0, 1'b1);
        scl = 1'b0;
        wait_clk(2);
    endtask : start_cond
    task automatic stop_cond();
        line_cond(1'b1, 1'b0);
    endtask : stop_cond
    task automatic bit_x(input logic b, output logic r);
        master_pull = !b;
        wait_clk(2);
        scl = 1'b1;
        wait_clk(4);
        r = sda;
        scl = 1'b0;
        wait_clk(2);
    endtask : bit_x
    // msb first, then the slave's ack is sampled
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(d[i], r);
        bit_x(1'b1, r);
        ack = !r;
    endtask : send_byte
    task automatic recv_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
        bit_x(nack, r);
    endtask : recv_byte
endmodule : dpg_master_model

// ===== verification/tb.sv
// self-checking bench of the pot/gain serial slave
// assumes the master model in place of the bus master and a short store count
`timescale 1ns/100ps
module tb;
    localparam int STORE = 300;
    logic                       clock, rst, write_lock, m_scl, m_pull, s_out, s_oe, busy, store, ack;
    logic [2:0]                 strap;
    logic [7:0]                 rd;
    logic [dpg_pkg::POT_W-1:0]  pot0, pot1;
    logic [dpg_pkg::GAIN_W-1:0] g0, g1;
    int                         errors, compares;
    // pull-up: high unless somebody pulls
    wire sda = !(m_pull || s_oe);
    dpg_master_model i_dpg_master_model (.clock(clock), .sda(sda), .scl(m_scl), .master_pull(m_pull));
    dpg_i2c_slave #(.STORE_CYCLES(STORE)) i_dpg_i2c_slave (.clock(clock), .rst(rst), .scl(m_scl), .sda(sda),
        .sda_out(s_out), .sda_oe(s_oe), .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
        .addr_strap_bit2(strap[2]), .write_lock(write_lock), .pot0_code(pot0), .pot1_code(pot1),
        .gain_stage_zero(g0), .gain_stage_one(g1), .nv_busy(busy), .nv_store_start(store));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    task automatic addr(input logic rw, input logic exp);
        i_dpg_master_model.send_byte({dpg_pkg::DEV_ADDR_HI, strap, rw}, ack);
        chk("address ack", {7'h0, exp}, {7'h0, ack});
    endtask : addr
    task automatic wr(input logic [7:0] r, input logic [7:0] d);
        i_dpg_master_model.start_cond();
        addr(1'b0, 1'b1);
        i_dpg_master_model.send_byte(r, ack);
        chk("register ack", 8'h01, {7'h0, ack});
        i_dpg_master_model.send_byte(d, ack);
        chk("data ack", 8'h01, {7'h0, ack});
    endtask : wr
    task automatic rd_now(input logic [7:0] exp);
        i_dpg_master_model.start_cond();
        addr(1'b1, 1'b1);
        i_dpg_master_model.recv_byte(1'b1, rd);
        i_dpg_master_model.stop_cond();
        chk("read data", exp, rd);
    endtask : rd_now
    task automatic wait_idle();
        for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(posedge clock);
        #1;
        chk("busy done", 8'h00, {7'h0, busy});
    endtask : wait_idle
    ////////////////////////////////////////////////////////////////////////
    task automatic t_defaults();
        chk("pot0 reset", 8'h1f, {2'h0, pot0});
        chk("pot1 reset", 8'h1f, {2'h0, pot1});
        chk("gain reset", 8'h11, {1'b0, g1, 1'b0, g0});
    endtask : t_defaults
    task automatic t_commit();
        wr(8'hf8, 8'hc5);
        chk("pot0 live", 8'h05, {2'h0, pot0});
        i_dpg_master_model.stop_cond();
        chk("busy after stop", 8'h01, {7'h0, busy});
        i_dpg_master_model.start_cond();
        addr(1'b0, 1'b0);
        i_dpg_master_model.stop_cond();
        wait_idle();
        i_dpg_master_model.start_cond();
        addr(1'b0, 1'b1);
        i_dpg_master_model.stop_cond();
    endtask : t_commit
    task automatic t_restart();
        wr(8'hf9, 8'h11);
        i_dpg_master_model.send_byte(8'h2a, ack);
        chk("pot1 rewrite", 8'h2a, {2'h0, pot1});
        chk("pot0 untouched", 8'h05, {2'h0, pot0});
        i_dpg_master_model.start_cond();
        addr(1'b1, 1'b1);
        chk("no busy on sr", 8'h00, {6'h0, busy, store});
        i_dpg_master_model.recv_byte(1'b1, rd);
        i_dpg_master_model.stop_cond();
        chk("pointer read", 8'h2a, rd);
        wait_idle();
    endtask : t_restart
    task automatic t_both_gain();
        wr(8'hfa, 8'h3f);
        i_dpg_master_model.stop_cond();
        chk("both pots pot0", 8'h3f, {2'h0, pot0});
        chk("both pots pot1", 8'h3f, {2'h0, pot1});
        wait_idle();
        rd_now(8'h00);
        wr(8'hfb, 8'hca);
        chk("gain live", 8'h42, {1'b0, g1, 1'b0, g0});
        i_dpg_master_model.start_cond();
        addr(1'b1, 1'b1);
        i_dpg_master_model.recv_byte(1'b0, rd);
        chk("gain read", 8'h42, rd);
        i_dpg_master_model.recv_byte(1'b1, rd);
        i_dpg_master_model.stop_cond();
        chk("gain reread", 8'h42, rd);
        wait_idle();
    endtask : t_both_gain
    task automatic t_wrong_addr();
        i_dpg_master_model.start_cond();
        i_dpg_master_model.send_byte({dpg_pkg::DEV_ADDR_HI, ~strap, 1'b0}, ack);
        chk("foreign ack", 8'h00, {7'h0, ack});
        i_dpg_master_model.send_byte(8'hf8, ack);
        i_dpg_master_model.send_byte(8'h00, ack);
        chk("foreign data ack", 8'h00, {7'h0, ack});
        i_dpg_master_model.stop_cond();
        chk("pot0 kept", 8'h3f, {2'h0, pot0});
    endtask : t_wrong_addr
    task automatic t_lock();
        write_lock = 1'b1;
        wr(8'hf8, 8'h00);
        i_dpg_master_model.stop_cond();
        chk("locked pot0", 8'h3f, {2'h0, pot0});
        chk("locked no busy", 8'h00, {7'h0, busy});
        rd_now(8'h3f);
        write_lock = 1'b0;
    endtask : t_lock
    initial begin
        errors = 0;
        compares = 0;
        rst = 1'b1;
        write_lock = 1'b0;
        strap = 3'b101;
        repeat (20) @(posedge clock);
        #1;
        rst = 1'b0;
        repeat (3) @(posedge clock);
        #1;
        t_defaults();
        t_commit();
        t_restart();
        t_both_gain();
        t_wrong_addr();
        t_lock();
        tally_and_finish();
    end
    // the tests take about 3000 cycles; allow over thirteen times that
    initial begin
        #320000;
        errors++;
        tally_and_finish();
    end
endmodule : tb
